//--- bench/tb.sv
// self-checking bench for the monitor configuration and alert mask bank
// assumes the bank's own assertions guard the cycle relations; this bench checks values
`timescale 1ns/100ps
module tb;
    import mon_cfg_pkg::*;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, lock_i = 1'b0;
    logic ext_single_channel_a_clk_en_i = 1'b0, pwm_polarity_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, status2_i = 8'h00, rdata_o;
    logic [2:0] single_sel_i = 3'h0, single_channel_a_channel_o;
    logic [3:0] tach_pin_i = 4'ha, sense_cmp_i = 4'h5, pwm_i = 4'h6;
    logic [3:0] tach_o, two_wire_sense_sel_o, pwm_o;
    logic [31:0] cur_duty_i = 32'h11223344, cur_duty_o;
    logic shutdown_ctl_o, no_averaging_o, bypass_divider_o, single_channel_a_o, single_channel_a_start_o, alert_n_o;
    logic [9:0] remote2_raw_i = 10'h000, remote2_temp_o;
    logic [6:0] status1_i = 7'h00;
    int err_total = 0;
    int checks = 0;
    always #4 mclk_i = ~mclk_i;
    mon_cfg_bank u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lock_i(lock_i), .single_sel_i(single_sel_i),
        .ext_single_channel_a_clk_en_i(ext_single_channel_a_clk_en_i), .pwm_polarity_i(pwm_polarity_i), .tach_pin_i(tach_pin_i),
        .sense_cmp_i(sense_cmp_i), .tach_o(tach_o), .two_wire_sense_sel_o(two_wire_sense_sel_o),
        .pwm_i(pwm_i), .cur_duty_i(cur_duty_i), .pwm_o(pwm_o), .cur_duty_o(cur_duty_o),
        .shutdown_ctl_o(shutdown_ctl_o), .no_averaging_o(no_averaging_o), .bypass_divider_o(bypass_divider_o),
        .single_channel_a_o(single_channel_a_o), .single_channel_a_channel_o(single_channel_a_channel_o), .single_channel_a_start_o(single_channel_a_start_o),
        .remote2_raw_i(remote2_raw_i), .remote2_temp_o(remote2_temp_o), .status1_i(status1_i),
        .status2_i(status2_i), .alert_n_o(alert_n_o));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", {24'h0, exp}, {24'h0, rdata_o});
        tick(1);
        chk("rdata idle", {24'h0, UNMAPPED_READ}, {24'h0, rdata_o});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        reg_rd(REMOTE2_TEMP_OFFSET_ADDR, 8'h00);
        reg_rd(CONFIG_TWO_ADDR, 8'h00);
        reg_rd(ALERT_MASK_ONE_ADDR, 8'h00);
        reg_rd(8'h75, UNMAPPED_READ);
        chk("cfg outputs", 32'h0, {shutdown_ctl_o, single_channel_a_o, bypass_divider_o, no_averaging_o,
            two_wire_sense_sel_o});
        chk("tach", 32'ha, tach_o);
    endtask
    task automatic t_config_fields();
        reg_wr(CONFIG_TWO_ADDR, 8'h73);
        reg_rd(CONFIG_TWO_ADDR, 8'h73);
        tick(5);
        chk("sense sel", 32'h3, two_wire_sense_sel_o);
        chk("tach mix", 32'h9, tach_o);
        chk("no avg", 32'h1, no_averaging_o);
        chk("bypass", 32'h1, bypass_divider_o);
        chk("single", 32'h1, single_channel_a_o);
        chk("pwm run", 32'h6, pwm_o);
        chk("duty run", 32'h11223344, cur_duty_o);
    endtask
    task automatic t_shutdown();
        reg_wr(CONFIG_TWO_ADDR, 8'h80);
        tick(3);
        chk("shutdown_ctl", 32'h1, shutdown_ctl_o);
        chk("pwm low", 32'h0, pwm_o);
        chk("duty zero", {24'h0, SHUTDOWN_DUTY}, cur_duty_o);
        pwm_polarity_i <= 1'b1;
        tick(3);
        chk("pwm high", 32'hf, pwm_o);
        reg_wr(CONFIG_TWO_ADDR, 8'h00);
        tick(3);
        chk("pwm resume", 32'h6, pwm_o);
        pwm_polarity_i <= 1'b0;
    endtask
    task automatic t_lock();
        reg_wr(REMOTE2_TEMP_OFFSET_ADDR, 8'h05);
        lock_i <= 1'b1;
        reg_wr(CONFIG_TWO_ADDR, 8'hff);
        reg_wr(REMOTE2_TEMP_OFFSET_ADDR, 8'haa);
        reg_wr(ALERT_MASK_ONE_ADDR, 8'h81);
        reg_rd(CONFIG_TWO_ADDR, 8'h00);
        reg_rd(REMOTE2_TEMP_OFFSET_ADDR, 8'h05);
        reg_rd(ALERT_MASK_ONE_ADDR, 8'h81);
        tick(2);
        chk("locked shutdown_ctl", 32'h0, shutdown_ctl_o);
        lock_i <= 1'b0;
        reg_wr(ALERT_MASK_ONE_ADDR, 8'h00);
    endtask
    task automatic t_offset();
        logic [9:0] raw [3] = '{10'd100, 10'h1ff, 10'h200};
        logic [7:0] off [3] = '{8'hf6, 8'h7f, 8'h80};
        logic [9:0] exp [3] = '{10'd90, 10'h1ff, 10'h200};
        for (int i = 0; i < 3; i++)
        begin
            remote2_raw_i <= raw[i];
            reg_wr(REMOTE2_TEMP_OFFSET_ADDR, off[i]);
            tick(3);
            chk("temp sum", {22'h0, exp[i]}, {22'h0, remote2_temp_o});
        end
    endtask
    task automatic t_alert();
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(ALERT_MASK_ONE_ADDR, 8'h00);
            status1_i <= 7'h01 << i;
            tick(3);
            chk("alert raw", 32'h0, alert_n_o);
            reg_wr(ALERT_MASK_ONE_ADDR, 8'h01 << i);
            tick(3);
            chk("alert own mask", 32'h1, alert_n_o);
            reg_wr(ALERT_MASK_ONE_ADDR, ~(8'h01 << i));
            tick(3);
            chk("alert other mask", 32'h0, alert_n_o);
        end
        status1_i <= 7'h00;
        status2_i <= 8'h90;
        reg_wr(ALERT_MASK_ONE_ADDR, 8'h7f);
        tick(3);
        chk("alert s2", 32'h0, alert_n_o);
        reg_wr(ALERT_MASK_ONE_ADDR, 8'h80);
        tick(3);
        chk("alert s2 mask", 32'h1, alert_n_o);
        status2_i <= 8'h00;
        reg_wr(ALERT_MASK_ONE_ADDR, 8'h00);
    endtask
    task automatic t_single();
        int n;
        reg_wr(CONFIG_TWO_ADDR, 8'h40);
        for (int s = 0; s < 8; s++)
        begin
            single_sel_i <= s[2:0];
            tick(2);
            chk("channel", s, single_channel_a_channel_o);
        end
        for (int e = 0; e < 2; e++)
        begin
            ext_single_channel_a_clk_en_i <= e[0];
            tach_pin_i <= 4'ha;
            tick(5);
            n = 0;
            tach_pin_i <= 4'hb;
            repeat (8)
            begin
                tick(1);
                n += int'(single_channel_a_start_o === 1'b1);
            end
            chk("single_channel_a starts", e, n);
        end
        ext_single_channel_a_clk_en_i <= 1'b0;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset_values();
        t_config_fields();
        t_shutdown();
        t_lock();
        t_offset();
        t_alert();
        t_single();
        end_of_test();
    end
    initial
    begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule // tb

//--- logic/alert_combine.sv
// gates out-of-limit flags with the alert mask
// assumes flags are level, same-clock status from the limit comparators
`timescale 1ns/100ps
module alert_combine
    import mon_cfg_pkg::*;
(
    // flags and mask
    input wire logic [6:0] status1_i,
    input wire logic [7:0] status2_i,
    input wire logic [7:0] mask_i,
    // combined request
    output logic alert_o
);
    logic [6:0] open1;
    logic open2;

    always_comb
    begin
        open1 = status1_i & ~mask_i[6:0];
        open2 = (|status2_i) & ~mask_i[STATUS2_MASK_BIT];
        alert_o = (|open1) | open2;
    end
endmodule // alert_combine

//--- logic/mon_cfg_bank.sv
// configuration, offset and alert mask registers of the fan and thermal monitor
// assumes a one-clock strobe port master; status, duty and lock inputs are same-clock
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
module mon_cfg_bank
    import mon_cfg_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // neighbouring register bits
    input wire logic lock_i,
    input wire logic [2:0] single_sel_i,
    input wire logic ext_single_channel_a_clk_en_i,
    input wire logic pwm_polarity_i,
    // fan pins
    input wire logic [FAN_COUNT-1:0] tach_pin_i,
    input wire logic [FAN_COUNT-1:0] sense_cmp_i,
    output logic [FAN_COUNT-1:0] tach_o,
    output logic [FAN_COUNT-1:0] two_wire_sense_sel_o,
    // pwm path
    input wire logic [FAN_COUNT-1:0] pwm_i,
    input wire logic [FAN_COUNT*8-1:0] cur_duty_i,
    output logic [FAN_COUNT-1:0] pwm_o,
    output logic [FAN_COUNT*8-1:0] cur_duty_o,
    output logic shutdown_ctl_o,
    // converter control
    output logic no_averaging_o,
    output logic bypass_divider_o,
    output logic single_channel_a_o,
    output logic [2:0] single_channel_a_channel_o,
    output logic single_channel_a_start_o,
    // temperature
    input wire logic [TEMP_W-1:0] remote2_raw_i,
    output logic [TEMP_W-1:0] remote2_temp_o,
    // alert
    input wire logic [6:0] status1_i,
    input wire logic [7:0] status2_i,
    output logic alert_n_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] config_two;
        logic [7:0] mask_one;
        logic [7:0] rdata;
        logic [FAN_COUNT-1:0] tach_s1;
        logic [FAN_COUNT-1:0] tach_s2;
        logic [FAN_COUNT-1:0] cmp_s1;
        logic [FAN_COUNT-1:0] cmp_s2;
        logic ext_prev;
        logic [FAN_COUNT-1:0] tach;
        logic [FAN_COUNT-1:0] pwm;
        logic [FAN_COUNT*8-1:0] duty;
        logic [2:0] channel;
        logic single_channel_a_start;
        logic [TEMP_W-1:0] temp;
        logic alert_n;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [TEMP_W-1:0] temp_sum;
    logic alert_req;
    logic shut;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    temp_offset_adder u_adder (
        .raw_i(remote2_raw_i),
        .offset_i(state_reg.offset),
        .sum_o(temp_sum)
    );

    alert_combine u_alert (
        .status1_i(status1_i),
        .status2_i(status2_i),
        .mask_i(state_reg.mask_one),
        .alert_o(alert_req)
    );

    assign shut = state_reg.config_two[SHUTDOWN_CTL_BIT];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.single_channel_a_start = 1'b0;
        if (wr_i)
        begin
            case (addr_i)
                REMOTE2_TEMP_OFFSET_ADDR:
                begin
                    if (!lock_i) state_next.offset = wdata_i;
                end
                CONFIG_TWO_ADDR:
                begin
                    if (!lock_i) state_next.config_two = wdata_i;
                end
                ALERT_MASK_ONE_ADDR:
                begin
                    state_next.mask_one = wdata_i;
                end
                default:
                begin
                    state_next.mask_one = state_reg.mask_one;
                end
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                REMOTE2_TEMP_OFFSET_ADDR: state_next.rdata = state_reg.offset;
                CONFIG_TWO_ADDR: state_next.rdata = state_reg.config_two;
                ALERT_MASK_ONE_ADDR: state_next.rdata = state_reg.mask_one;
                default: state_next.rdata = UNMAPPED_READ;
            endcase
        end
        else
        begin
            state_next.rdata = UNMAPPED_READ;
        end
        // pin synchronisers
        state_next.tach_s1 = tach_pin_i;
        state_next.tach_s2 = state_reg.tach_s1;
        state_next.cmp_s1 = sense_cmp_i;
        state_next.cmp_s2 = state_reg.cmp_s1;
        state_next.ext_prev = state_reg.tach_s2[EXT_CLK_PIN];
        // speed sensing source per fan
        for (int i = 0; i < FAN_COUNT; i++)
        begin
            state_next.tach[i] = state_reg.config_two[TWO_WIRE_SENSE_SEL_LSB+i] ?
                state_reg.cmp_s2[i] : state_reg.tach_s2[i];
        end
        // pwm and duty in shutdown
        state_next.pwm = shut ? {FAN_COUNT{pwm_polarity_i}} : pwm_i;
        state_next.duty = shut ? {FAN_COUNT{SHUTDOWN_DUTY}} : cur_duty_i;
        // single channel conversion
        state_next.channel = single_sel_i;
        if (state_reg.config_two[SINGLE_CHANNEL_A_BIT] && ext_single_channel_a_clk_en_i
            && state_reg.tach_s2[EXT_CLK_PIN] && !state_reg.ext_prev)
        begin
            state_next.single_channel_a_start = 1'b1;
        end
        state_next.temp = temp_sum;
        state_next.alert_n = !alert_req;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= '0;
            state_reg.offset <= REMOTE2_TEMP_OFFSET_RST;
            state_reg.config_two <= CONFIG_TWO_RST;
            state_reg.mask_one <= ALERT_MASK_ONE_RST;
            state_reg.alert_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = state_reg.rdata;
    assign tach_o = state_reg.tach;
    assign two_wire_sense_sel_o = state_reg.config_two[TWO_WIRE_SENSE_SEL_LSB +: FAN_COUNT];
    assign pwm_o = state_reg.pwm;
    assign cur_duty_o = state_reg.duty;
    assign shutdown_ctl_o = state_reg.config_two[SHUTDOWN_CTL_BIT];
    assign no_averaging_o = state_reg.config_two[NO_AVERAGING_BIT];
    assign bypass_divider_o = state_reg.config_two[BYPASS_DIVIDER_BIT];
    assign single_channel_a_o = state_reg.config_two[SINGLE_CHANNEL_A_BIT];
    assign single_channel_a_channel_o = state_reg.channel;
    assign single_channel_a_start_o = state_reg.single_channel_a_start;
    assign remote2_temp_o = state_reg.temp;
    assign alert_n_o = state_reg.alert_n;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    offset_lock_a: assert property (
        (wr_i && lock_i && addr_i == REMOTE2_TEMP_OFFSET_ADDR) |=> $stable(state_reg.offset))
        else $error("offset changed while locked");

    config_lock_a: assert property (
        (wr_i && lock_i && addr_i == CONFIG_TWO_ADDR) |=> $stable(shutdown_ctl_o) && $stable(no_averaging_o))
        else $error("config changed while locked");

    config_write_a: assert property (
        (wr_i && !lock_i && addr_i == CONFIG_TWO_ADDR) ##1 (rd_i && addr_i == CONFIG_TWO_ADDR)
        |=> rdata_o == $past(wdata_i, 2) && no_averaging_o == rdata_o[NO_AVERAGING_BIT])
        else $error("config write not read back");

    pwm_off_a: assert property (
        shutdown_ctl_o |=> pwm_o == {FAN_COUNT{$past(pwm_polarity_i)}})
        else $error("pwm not at fan-off level");

    duty_zero_a: assert property (
        shutdown_ctl_o [*2] |-> cur_duty_o == '0)
        else $error("duty not zero in shutdown");

    sense_mux_a: assert property (
        $past(two_wire_sense_sel_o[0]) |-> tach_o[0] == $past(sense_cmp_i[0], 3))
        else $error("two-wire sense not selected");

    status2_mask_a: assert property (
        (state_reg.mask_one[STATUS2_MASK_BIT] && status1_i == '0) |=> alert_n_o)
        else $error("status 2 alert not masked");

    alert_unmask_a: assert property (
        (|(status1_i & ~state_reg.mask_one[6:0])) |=> !alert_n_o)
        else $error("unmasked flag gave no alert");

    temp_zero_a: assert property (
        (state_reg.offset == '0) |=> remote2_temp_o == $past(remote2_raw_i))
        else $error("zero offset altered temperature");

    ext_start_a: assert property (
        single_channel_a_start_o |-> single_channel_a_o && $past(ext_single_channel_a_clk_en_i))
        else $error("conversion start outside single mode");

    shutdown_c: cover property (wr_i && addr_i == CONFIG_TWO_ADDR && wdata_i[SHUTDOWN_CTL_BIT] ##1 shutdown_ctl_o);
    lock_c: cover property (wr_i && lock_i && addr_i == REMOTE2_TEMP_OFFSET_ADDR);
    alert_c: cover property ($fell(alert_n_o));
    start_c: cover property (single_channel_a_start_o);

endmodule // mon_cfg_bank

//--- logic/temp_offset_adder.sv
// adds a signed quarter-degree offset to a 10-bit signed temperature
// assumes both operands share the quarter-degree unit; saturates at the range ends
`timescale 1ns/100ps
module temp_offset_adder
    import mon_cfg_pkg::*;
(
    // operands
    input wire logic [TEMP_W-1:0] raw_i,
    input wire logic [7:0] offset_i,
    // result
    output logic [TEMP_W-1:0] sum_o
);
    logic signed [TEMP_W:0] wide;

    always_comb
    begin
        wide = $signed({raw_i[TEMP_W-1], raw_i}) + $signed({{(TEMP_W-7){offset_i[7]}}, offset_i});
        if (wide[TEMP_W] != wide[TEMP_W-1])
        begin
            sum_o = wide[TEMP_W] ? {1'b1, {(TEMP_W-1){1'b0}}} : {1'b0, {(TEMP_W-1){1'b1}}};
        end
        else
        begin
            sum_o = wide[TEMP_W-1:0];
        end
    end
endmodule // temp_offset_adder

//--- shared/mon_cfg_pkg.sv
// constants for the monitor configuration and alert mask bank
// assumes an 8-bit register address space on a plain strobe port
package mon_cfg_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] REMOTE2_TEMP_OFFSET_ADDR = 8'h72;
    localparam logic [7:0] CONFIG_TWO_ADDR = 8'h73;
    localparam logic [7:0] ALERT_MASK_ONE_ADDR = 8'h74;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] REMOTE2_TEMP_OFFSET_RST = 8'h00;
    localparam logic [7:0] CONFIG_TWO_RST = 8'h00;
    localparam logic [7:0] ALERT_MASK_ONE_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] SHUTDOWN_DUTY = 8'h00;

    // ----------------------------------------
    // config_two field positions
    // ----------------------------------------
    localparam int TWO_WIRE_SENSE_SEL_LSB = 0;
    localparam int NO_AVERAGING_BIT = 4;
    localparam int BYPASS_DIVIDER_BIT = 5;
    localparam int SINGLE_CHANNEL_A_BIT = 6;
    localparam int SHUTDOWN_CTL_BIT = 7;

    // ----------------------------------------
    // alert_mask_one field positions
    // ----------------------------------------
    localparam int VOLT_MASK_LSB = 0;
    localparam int REMOTE1_TEMP_MASK_BIT = 4;
    localparam int LOCAL_TEMP_MASK_BIT = 5;
    localparam int REMOTE2_TEMP_MASK_BIT = 6;
    localparam int STATUS2_MASK_BIT = 7;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int FAN_COUNT = 4;
    localparam int TEMP_W = 10;
    localparam int EXT_CLK_PIN = 0;

endpackage
